// ===== debug_lock_defines.svh
// Purpose: Addresses, patterns and counts for the debug lock and boot security block.
// Assumes: 16-bit nonvolatile words, byte addresses, low word at the lower address.
// Notes: Definitions only.
`ifndef DEBUG_LOCK_DEFINES_SVH
`define DEBUG_LOCK_DEFINES_SVH

// ==========================================================================
// Address map
`define DL_SEC_BASE 16'hFF80
`define DL_SIG_DBG_ADDR 16'hFF80
`define DL_SIG_BL_ADDR 16'hFF84
`define DL_DBG_PW_ADDR 16'hFF88
`define DL_PW_CFG_ADDR 16'hFF90
`define DL_DEV_PW_ADDR 16'hFFE0
`define DL_INFO_LO 16'h1800
`define DL_INFO_HI 16'h19FF
`define DL_CAL_LO 16'h1A00
`define DL_CAL_HI 16'h1AFF

// ==========================================================================
// Signature patterns and fields
`define DL_SIG_OPEN 32'h0000_0000
`define DL_SIG_BYPASS 32'h5555_5555
`define DL_SIG_DISABLE 32'hFFFF_FFFF
`define DL_PW_EN_BIT 15
`define DL_PW_LEN_MSB 1
`define DL_PW_LEN_LSB 0

// ==========================================================================
// Counts
`define DL_SCAN_LAST 3'h4
`define DL_DEV_PW_LAST 4'hF
`define DL_WORD_LAST 4'hF

`endif

// ===== debug_lock_pkg.sv
// Purpose: Types shared by the debug lock and boot security block.
// Assumes: The defines header is included by every user.
// Notes: None.
package debug_lock_pkg;

  // ==========================================================================
  // Requesters of memory access
  typedef enum logic [1:0] {
    SRC_APP = 2'h0,
    SRC_BOOT = 2'h1,
    SRC_DEBUG = 2'h2
  } src_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic erase;
    src_t src;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic rvalid;
    logic denied;
    logic [15:0] rdata;
  } mem_rsp_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic erase;
    logic [15:0] addr;
    logic [15:0] wdata;
  } nvm_cmd_t;

  // ==========================================================================
  // Control state
  typedef enum logic [4:0] {
    ST_INIT = 5'h01,
    ST_SCAN = 5'h02,
    ST_RUN = 5'h04,
    ST_CHECK = 5'h08,
    ST_READ = 5'h10
  } state_e_t;

  typedef struct packed {
    logic valid;
    logic dbg;
    logic [15:0] word;
  } cmp_t;

endpackage : debug_lock_pkg

// ===== sec_page_mem.sv
// Purpose: Word store for the security page at the top of nonvolatile memory.
// Assumes: One write and one read per cycle, read data registered.
// Notes: Contents are not reset, as befits nonvolatile storage.
`timescale 1ns/1ns
`default_nettype none

module sec_page_mem (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [15:0] wdata,
  // Read port
  input wire logic [5:0] raddr,
  output logic [15:0] rdata
);

  logic [15:0] mem [0:63];

  // ==========================================================================
  // Storage
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : sec_page_mem

`default_nettype wire

// ===== debug_lock_security.sv
// Purpose: Reset-time signature evaluation, debug port lock, boot loader gating and memory guards.
// Assumes: rstn is the brownout reset; debug link pins are asynchronous to clk.
// Notes: The security page FF80h to FFFFh lives in sec_page_mem; other accesses go out on nvm_cmd.
`timescale 1ns/1ns
`default_nettype none

`include "debug_lock_defines.svh"

// What this block does
// - Debug lock signature is the 32-bit word at FF80h to FF83h.
// - An all-zero debug signature leaves the debug port open; anything else locks it.
// - Boot signature 5555_5555h bypasses the boot loader; user code starts at once.
// - Boot signatures other than 5555_5555h and FFFF_FFFFh run the boot loader on entry and demand its password.
// - The 32 bytes FFE0h to FFFFh serve as the boot loader password.
// - A locked debug port refuses all access; apart from the application, only a verified boot loader gets in.
// - A verified boot loader may clear the debug signature, reopening the debug port.
// - Optional debug password of one to four words stored from FF88h.
// - A wrong debug password keeps the debug port closed.
// - With an all-zero debug signature, a verified debug password opens the port until the next brownout reset.
// - The calibration table cannot be erased or written by any requester.
// - Information memory 1800h to 19FFh stays readable and writable.
// - Boot signature FFFF_FFFFh disables the boot loader and its signature clearing.
module debug_lock_security (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Boot loader entry pin and password words
  input wire logic bl_entry,
  input wire logic bl_pw_valid,
  input wire logic bl_pw_first,
  input wire logic [15:0] bl_pw_word,
  output logic bl_pw_ready,
  // Two-wire debug link pins
  input wire logic two_wire_debug_clk,
  input wire logic two_wire_debug_dat,
  input wire logic two_wire_debug_en,
  // Memory requests and answers
  input wire debug_lock_pkg::mem_req_t mem_req,
  output logic mem_ready,
  output debug_lock_pkg::mem_rsp_t mem_rsp,
  output debug_lock_pkg::nvm_cmd_t nvm_cmd,
  // Security decisions
  output logic cpu_release,
  output logic boot_loader_run,
  output logic bl_unlocked,
  output logic dbg_open,
  output logic dbg_pw_fail
);
  import debug_lock_pkg::*;

  typedef struct packed {
    state_e_t st;
    logic [2:0] idx;
    logic [15:0] rd_addr;
    logic [31:0] sig_dbg;
    logic [31:0] sig_bl;
    logic [15:0] pw_cfg;
    logic decided;
    logic bl_run;
    logic bl_ok;
    logic [3:0] bl_idx;
    logic pw_ok;
    logic pw_fail;
    logic [1:0] pw_idx;
    cmp_t cmp;
    logic [2:0] dclk;
    logic [1:0] ddat;
    logic [1:0] den;
    logic [1:0] entry;
    logic [3:0] bit_cnt;
    logic [15:0] shift;
    mem_rsp_t rsp;
    nvm_cmd_t nvm;
  } state_t;

  state_t s;
  state_t next_s;
  logic [15:0] rdata;
  logic mem_we;
  logic bypass;
  logic disabled;
  logic pw_mode;
  logic dbg_rise;
  logic take;
  logic deny;

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] scan_addr(input logic [2:0] i);
    if (i == 3'h4) begin
      scan_addr = `DL_PW_CFG_ADDR;
    end else begin
      scan_addr = `DL_SIG_DBG_ADDR + {12'h000, i, 1'b0};
    end
  endfunction : scan_addr

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic refuse(input mem_req_t r, input logic open, input logic unlocked);
    if (in_range(r.addr, `DL_CAL_LO, `DL_CAL_HI) && (r.write || r.erase)) begin
      refuse = 1'b1;
    end else if (r.src == SRC_DEBUG) begin
      refuse = !open;
    end else if (r.src == SRC_BOOT) begin
      refuse = !unlocked;
    end else begin
      refuse = 1'b0;
    end
  endfunction : refuse

  // ==========================================================================
  // Decisions
  assign bypass = (s.sig_bl == `DL_SIG_BYPASS);
  assign disabled = (s.sig_bl == `DL_SIG_DISABLE);
  assign pw_mode = s.pw_cfg[`DL_PW_EN_BIT];
  assign dbg_rise = s.dclk[1] && !s.dclk[2];
  assign mem_ready = (s.st == ST_RUN) && !s.cmp.valid;
  assign take = mem_ready && mem_req.valid;
  assign deny = refuse(mem_req, dbg_open, s.bl_ok);
  assign mem_we = take && !deny && mem_req.write && (mem_req.addr >= `DL_SEC_BASE);
  assign bl_pw_ready = !s.cmp.valid;
  assign cpu_release = s.decided;
  assign boot_loader_run = s.bl_run;
  assign bl_unlocked = s.bl_ok;
  assign dbg_pw_fail = s.pw_fail;
  assign dbg_open = s.decided && (s.sig_dbg == `DL_SIG_OPEN) && (!pw_mode || s.pw_ok);
  assign mem_rsp = s.rsp;
  assign nvm_cmd = s.nvm;

  // ==========================================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.dclk = {s.dclk[1:0], two_wire_debug_clk};
    next_s.ddat = {s.ddat[0], two_wire_debug_dat};
    next_s.den = {s.den[0], two_wire_debug_en};
    next_s.entry = {s.entry[0], bl_entry};
    next_s.rsp.rvalid = 1'b0;
    next_s.rsp.denied = 1'b0;
    next_s.nvm.valid = 1'b0;
    if (!s.den[1]) begin
      next_s.bit_cnt = 4'h0;
    end else if (dbg_rise) begin
      next_s.shift = {s.shift[14:0], s.ddat[1]};
      next_s.bit_cnt = s.bit_cnt + 4'h1;
      if (s.bit_cnt == `DL_WORD_LAST && s.decided && pw_mode && !s.pw_ok && !s.pw_fail && !s.cmp.valid) begin
        next_s.cmp = '{valid: 1'b1, dbg: 1'b1, word: {s.shift[14:0], s.ddat[1]}};
      end
    end
    if (bl_pw_valid && !s.cmp.valid && s.decided && !bypass && !disabled) begin
      next_s.cmp = '{valid: 1'b1, dbg: 1'b0, word: bl_pw_word};
      if (bl_pw_first) begin
        next_s.bl_idx = 4'h0;
      end
    end
    case (s.st)
      ST_INIT: begin
        next_s.idx = 3'h0;
        next_s.rd_addr = scan_addr(3'h0);
        next_s.st = ST_SCAN;
      end
      ST_SCAN: begin
        case (s.idx)
          3'h0: next_s.sig_dbg[15:0] = rdata;
          3'h1: next_s.sig_dbg[31:16] = rdata;
          3'h2: next_s.sig_bl[15:0] = rdata;
          3'h3: next_s.sig_bl[31:16] = rdata;
          default: next_s.pw_cfg = rdata;
        endcase
        next_s.idx = s.idx + 3'h1;
        next_s.rd_addr = scan_addr(s.idx + 3'h1);
        if (s.idx == `DL_SCAN_LAST) begin
          next_s.decided = 1'b1;
          next_s.bl_run = s.entry[1] && (s.sig_bl != `DL_SIG_BYPASS) && (s.sig_bl != `DL_SIG_DISABLE);
          next_s.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (s.cmp.valid) begin
          if (s.cmp.dbg) begin
            next_s.rd_addr = `DL_DBG_PW_ADDR + {13'h0000, s.pw_idx, 1'b0};
          end else begin
            next_s.rd_addr = `DL_DEV_PW_ADDR + {11'h000, s.bl_idx, 1'b0};
          end
          next_s.st = ST_CHECK;
        end else if (take) begin
          next_s.rd_addr = mem_req.addr;
          if (deny) begin
            next_s.rsp.denied = 1'b1;
          end else if (mem_req.addr >= `DL_SEC_BASE) begin
            if (mem_req.write && mem_req.addr[15:2] == `DL_SIG_DBG_ADDR >> 2) begin
              if (mem_req.addr[1]) begin
                next_s.sig_dbg[31:16] = mem_req.wdata;
              end else begin
                next_s.sig_dbg[15:0] = mem_req.wdata;
              end
            end
            if (!mem_req.write && !mem_req.erase) begin
              next_s.st = ST_READ;
            end
          end else begin
            next_s.nvm = '{valid: 1'b1, write: mem_req.write, erase: mem_req.erase,
                           addr: mem_req.addr, wdata: mem_req.wdata};
          end
        end
      end
      ST_CHECK: begin
        next_s.cmp.valid = 1'b0;
        next_s.st = ST_RUN;
        if (s.cmp.dbg) begin
          if (rdata != s.cmp.word) begin
            next_s.pw_fail = 1'b1;
          end else if (s.pw_idx == s.pw_cfg[`DL_PW_LEN_MSB:`DL_PW_LEN_LSB]) begin
            next_s.pw_ok = 1'b1;
          end else begin
            next_s.pw_idx = s.pw_idx + 2'h1;
          end
        end else begin
          if (rdata != s.cmp.word) begin
            next_s.bl_idx = 4'h0;
          end else if (s.bl_idx == `DL_DEV_PW_LAST) begin
            next_s.bl_ok = 1'b1;
          end else begin
            next_s.bl_idx = s.bl_idx + 4'h1;
          end
        end
      end
      ST_READ: begin
        next_s.rsp.rvalid = 1'b1;
        next_s.rsp.rdata = rdata;
        next_s.st = ST_RUN;
      end
      default: begin
        next_s.st = ST_INIT;
      end
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
      s.st <= ST_INIT;
    end else begin
      s <= next_s;
    end
  end

  sec_page_mem u_mem (
    .clk(clk),
    .we(mem_we),
    .waddr(mem_req.addr[6:1]),
    .wdata(mem_req.wdata),
    .raddr(next_s.rd_addr[6:1]),
    .rdata(rdata)
  );

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  lock_signature_a: assert property (dbg_open |-> s.sig_dbg == 32'h0)
    else $error("Debug port open with a nonzero signature.");
  bypass_skip_a: assert property (cpu_release && bypass |-> !boot_loader_run)
    else $error("Boot loader runs despite bypass signature.");
  disable_block_a: assert property (disabled |-> !boot_loader_run && !bl_unlocked)
    else $error("Disabled boot loader became active.");
  debug_refuse_a: assert property (take && mem_req.src == SRC_DEBUG && !dbg_open |=> mem_rsp.denied)
    else $error("Locked debug port access not refused.");
  cal_protect_a: assert property (take && mem_req.write && mem_req.addr inside {[16'h1A00:16'h1AFF]}
    |=> mem_rsp.denied && !nvm_cmd.valid)
    else $error("Calibration table write not blocked.");
  info_pass_a: assert property (take && mem_req.src == SRC_APP && mem_req.addr inside {[16'h1800:16'h19FF]}
    |=> nvm_cmd.valid && nvm_cmd.addr == $past(mem_req.addr))
    else $error("Information memory access not passed on.");
  wrong_pw_a: assert property (dbg_pw_fail |-> !dbg_open)
    else $error("Debug port open after a wrong password.");
  pw_hold_a: assert property (s.pw_ok |=> s.pw_ok[*3])
    else $error("Verified debug password lost before reset.");
  release_scan_a: assert property ($rose(cpu_release) |-> $past(s.st) == ST_SCAN && $past(s.idx) == 3'h4)
    else $error("Release without a full signature scan.");
  run_hold_a: assert property (cpu_release |=> $stable(boot_loader_run))
    else $error("Boot loader decision changed after release.");
  boot_refuse_a: assert property (take && mem_req.src == SRC_BOOT && !bl_unlocked |=> mem_rsp.denied)
    else $error("Locked boot loader access not refused.");
  pw_gate_a: assert property (pw_mode && !s.pw_ok |-> !dbg_open)
    else $error("Debug port open before the debug password was verified.");
  denied_quiet_a: assert property (mem_rsp.denied |-> !nvm_cmd.valid && !mem_rsp.rvalid)
    else $error("Refused access still produced a memory command or read data.");
  scan_hold_a: assert property (!cpu_release |-> !mem_ready && !boot_loader_run && !dbg_open)
    else $error("Access or boot loader active before the signature scan ended.");
  fail_hold_a: assert property (dbg_pw_fail |=> dbg_pw_fail)
    else $error("Wrong debug password flag lost before reset.");

endmodule : debug_lock_security

`default_nettype wire

// ===== debug_tool_model.sv
// Purpose: Behavioural debug tool that sends a password word on the two-wire link.
// Assumes: The link clock runs only inside a frame, at a 32 ns period.
// Notes: The data line has no pull, so it shows the inverted last bit after a frame.
`timescale 1ns/1ns
`default_nettype none

module debug_tool_model (
  // Request from the bench
  input wire logic go,
  input wire logic [15:0] word,
  // Two-wire link pins
  output var logic link_clk,
  output var logic link_dat,
  output var logic link_en,
  // Status
  output var logic busy
);
  // ====================
  // Frame sender
  initial begin
    link_clk = 1'b0;
    link_dat = 1'b1;
    link_en = 1'b0;
    busy = 1'b0;
  end

  // One frame holds one password word, sent ahead of any other operation.
  always @(posedge go) begin
    busy = 1'b1;
    #3 link_en = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      link_dat = word[i];
      #16 link_clk = 1'b1;
      #16 link_clk = 1'b0;
    end
    #16 link_en = 1'b0;
    link_dat = ~link_dat;
    busy = 1'b0;
  end
endmodule : debug_tool_model

`default_nettype wire

// ===== testbench.sv
// Purpose: Self-checking bench for the debug lock and boot security block.
// Assumes: The security page is programmed by application writes, then reset.
// Notes: Each scenario is a task that judges its own results.
`timescale 1ns/1ns
`default_nettype none

`include "debug_lock_defines.svh"

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module testbench;
  import debug_lock_pkg::*;

  // ====================
  // Signals
  logic clk, rstn, bl_entry, bl_pw_valid, bl_pw_first, bl_pw_ready;
  logic [15:0] bl_pw_word, tool_word, got_rd, got_na;
  logic sw_clk, sw_dat, sw_en, tool_go, tool_busy;
  mem_req_t mem_req;
  mem_rsp_t mem_rsp;
  nvm_cmd_t nvm_cmd;
  logic mem_ready, cpu_release, boot_loader_run, bl_unlocked, dbg_open, dbg_pw_fail;
  logic got_den, got_nvm, got_rv;
  logic [17:0] got_nw;
  int err_total, tests_run, n;

  debug_lock_security u_debug_lock_security (.clk(clk), .rstn(rstn), .bl_entry(bl_entry),
    .bl_pw_valid(bl_pw_valid), .bl_pw_first(bl_pw_first), .bl_pw_word(bl_pw_word),
    .bl_pw_ready(bl_pw_ready), .two_wire_debug_clk(sw_clk), .two_wire_debug_dat(sw_dat),
    .two_wire_debug_en(sw_en), .mem_req(mem_req), .mem_ready(mem_ready), .mem_rsp(mem_rsp),
    .nvm_cmd(nvm_cmd), .cpu_release(cpu_release), .boot_loader_run(boot_loader_run),
    .bl_unlocked(bl_unlocked), .dbg_open(dbg_open), .dbg_pw_fail(dbg_pw_fail));

  debug_tool_model u_debug_tool_model (.go(tool_go), .word(tool_word), .link_clk(sw_clk),
    .link_dat(sw_dat), .link_en(sw_en), .busy(tool_busy));

  // ====================
  // Helpers
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  task automatic do_reset();
    rstn = 1'b0;
    repeat (16) @(posedge clk);
    #1 rstn = 1'b1;
    n = 0;
    while (cpu_release !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK(n, 6)
  endtask : do_reset

  task automatic mem_access(input src_t src, input logic wr, input logic er, input logic [15:0] a,
                            input logic [15:0] d);
    @(posedge clk);
    #1 mem_req = '{1'b1, wr, er, src, a, d};
    n = 0;
    while (mem_ready !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 20) begin
      err_total++;
    end
    @(posedge clk);
    #1 mem_req.valid = 1'b0;
    {got_den, got_nvm, got_rv} = 3'h0;
    got_nw = 18'h3FFFF;
    repeat (4) begin
      got_den = got_den | (mem_rsp.denied === 1'b1);
      if (nvm_cmd.valid === 1'b1) begin
        got_nvm = 1'b1;
        got_na = nvm_cmd.addr;
        got_nw = {nvm_cmd.write, nvm_cmd.erase, nvm_cmd.wdata};
      end
      if (mem_rsp.rvalid === 1'b1) begin
        got_rv = 1'b1;
        got_rd = mem_rsp.rdata;
      end
      cyc(1);
    end
  endtask : mem_access

  task automatic prog(input logic [15:0] a, input logic [15:0] d);
    mem_access(SRC_APP, 1'b1, 1'b0, a, d);
  endtask : prog

  task automatic bl_password(input logic bad);
    for (int i = 0; i < 16; i++) begin
      bl_pw_word = (bad && i == 5) ? 16'h0BAD : 16'(16'hB000 + i);
      bl_pw_first = (i == 0);
      bl_pw_valid = 1'b1;
      `CHK(bl_pw_ready, 1'b1)
      cyc(1);
      bl_pw_valid = 1'b0;
      cyc(3);
    end
    cyc(10);
  endtask : bl_password

  task automatic tool_send(input logic [15:0] w);
    tool_word = w;
    tool_go = 1'b1;
    cyc(1);
    tool_go = 1'b0;
    n = 0;
    while (tool_busy === 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    if (n >= 300) begin
      err_total++;
    end
    cyc(30);
  endtask : tool_send

  // ====================
  // Scenarios
  task automatic t_locked();
    do_reset();
    `CHK(dbg_open, 1'b0)
    `CHK(boot_loader_run, 1'b1)
    mem_access(SRC_DEBUG, 1'b0, 1'b0, `DL_SIG_DBG_ADDR, 16'h0000);
    `CHK(got_den, 1'b1)
    mem_access(SRC_APP, 1'b0, 1'b0, `DL_SIG_DBG_ADDR, 16'h0000);
    `CHK(got_rd, 16'h1234)
    mem_access(SRC_APP, 1'b1, 1'b0, `DL_CAL_LO, 16'h00FF);
    `CHK(got_den, 1'b1)
    mem_access(SRC_APP, 1'b0, 1'b1, `DL_CAL_HI, 16'h0000);
    `CHK({got_den, got_nvm}, 2'h2)
    mem_access(SRC_APP, 1'b1, 1'b0, `DL_INFO_LO, 16'hA5A5);
    `CHK({got_den, got_nvm, got_na}, {2'h1, `DL_INFO_LO})
    `CHK(got_nw, {2'h2, 16'hA5A5})
    mem_access(SRC_APP, 1'b0, 1'b0, `DL_INFO_HI, 16'h0000);
    `CHK({got_den, got_nvm, got_na}, {2'h1, `DL_INFO_HI})
    `CHK(got_nw, {2'h0, 16'h0000})
  endtask : t_locked

  task automatic t_boot_pw();
    bl_password(1'b1);
    `CHK(bl_unlocked, 1'b0)
    bl_password(1'b0);
    `CHK(bl_unlocked, 1'b1)
    mem_access(SRC_BOOT, 1'b0, 1'b1, `DL_CAL_LO, 16'h0000);
    `CHK(got_den, 1'b1)
    mem_access(SRC_BOOT, 1'b1, 1'b0, `DL_SIG_DBG_ADDR, 16'h0000);
    mem_access(SRC_BOOT, 1'b1, 1'b0, 16'hFF82, 16'h0000);
    `CHK(dbg_open, 1'b1)
  endtask : t_boot_pw

  task automatic t_dbg_pw();
    prog(`DL_PW_CFG_ADDR, 16'h8000);
    do_reset();
    `CHK(dbg_open, 1'b0)
    tool_send(16'hC35B);
    `CHK({dbg_pw_fail, dbg_open}, 2'h2)
    do_reset();
    `CHK(dbg_pw_fail, 1'b0)
    tool_send(16'hC35A);
    `CHK({dbg_pw_fail, dbg_open}, 2'h1)
    mem_access(SRC_DEBUG, 1'b0, 1'b0, `DL_DBG_PW_ADDR, 16'h0000);
    `CHK({got_den, got_rv, got_rd}, {2'h1, 16'hC35A})
    bl_entry = 1'b0;
    do_reset();
    `CHK(dbg_open, 1'b0)
    `CHK(boot_loader_run, 1'b0)
    bl_entry = 1'b1;
    prog(`DL_PW_CFG_ADDR, 16'h0000);
  endtask : t_dbg_pw

  task automatic t_bypass(input logic [31:0] sig);
    prog(`DL_SIG_DBG_ADDR, 16'h1234);
    prog(`DL_SIG_BL_ADDR, sig[15:0]);
    prog(16'hFF86, sig[31:16]);
    do_reset();
    `CHK(boot_loader_run, 1'b0)
    bl_password(1'b0);
    `CHK(bl_unlocked, 1'b0)
    mem_access(SRC_BOOT, 1'b1, 1'b0, `DL_SIG_DBG_ADDR, 16'h0000);
    `CHK({got_den, dbg_open}, 2'h2)
  endtask : t_bypass

  // ====================
  // Verdict and sequence
  task automatic print_verdict();
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #100000;
    err_total++;
    print_verdict();
  end

  initial begin
    {rstn, bl_entry, bl_pw_valid, bl_pw_first, tool_go} = 5'h00;
    {bl_pw_word, tool_word} = 32'h0000_0000;
    mem_req = '0;
    {err_total, tests_run} = {32'd0, 32'd0};
    do_reset();
    prog(`DL_SIG_DBG_ADDR, 16'h1234);
    prog(16'hFF82, 16'h0000);
    prog(`DL_SIG_BL_ADDR, 16'h0001);
    prog(16'hFF86, 16'h0000);
    prog(`DL_DBG_PW_ADDR, 16'hC35A);
    prog(`DL_PW_CFG_ADDR, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      prog(16'(16'hFFE0 + 2 * i), 16'(16'hB000 + i));
    end
    bl_entry = 1'b1;
    t_locked();
    t_boot_pw();
    t_dbg_pw();
    t_bypass(`DL_SIG_BYPASS);
    t_bypass(`DL_SIG_DISABLE);
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
